// File: verilog/ddti_drive.sv
// Drive-side tag interface: select, addressing, control functions and status
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ddti_drive
  import ddti_pkg::*;
#(
  parameter int OFFSET_SETTLE = OFFSET_SETTLE_CYC,
  parameter int BYTES_PER_TRACK = 20160,
  parameter bit FIXED_HEAD = 1'b0
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire ddti_apb_req_t apb_req,
  output ddti_apb_rsp_t apb_rsp,
  input wire ddti_cable_t cable,
  input wire ddti_sense_t sense,
  output ddti_stat_t stat,
  output ddti_cmd_t cmd
);

  typedef struct packed {
    ddti_seek_t sk;
    ddti_stat_t stat;
    ddti_cmd_t cmd;
    logic cyl_tag_d;
    logic head_tag_d;
    logic read_gate_d;
    logic [1:0] offset_d;
    logic [19:0] settle;
    logic [11:0] blank;
    logic [4:0] miss_cnt;
    logic mark_done;
    logic [9:0] mark_cnt;
    logic [13:0] sec_bytes;
    logic [15:0] trk_bytes;
    logic [8:0] index_cnt;
    logic [8:0] sector_cnt;
    logic [31:0] cfg;
    ddti_apb_rsp_t rsp;
  } ddti_state_t;

  ddti_state_t st_r;
  ddti_state_t st_nxt;
  logic fault_clear_hit;
  logic rtz_hit;
  logic [9:0] ctrl;
  logic selected;

  initial begin
    if (OFFSET_SETTLE < 1 || OFFSET_SETTLE > 1048575) begin
      $error("ddti_drive: OFFSET_SETTLE out of range");
    end
    if (BYTES_PER_TRACK < 2 || BYTES_PER_TRACK > 65535) begin
      $error("ddti_drive: BYTES_PER_TRACK out of range");
    end
  end

  // Control lines count only while the selected unit sees the control tag
  assign selected = st_r.stat.unit_selected;
  assign ctrl = (cable.ctrl_tag && selected) ? cable.bus : 10'h000;

  // Fault clear and zero return must be held a minimum time to count
  ddti_width_qual #(.MIN_CYC(FAULT_CLR_CYC)) u_fault_clear (
    .clk_sys(clk_sys),
    .srst(srst),
    .level(ctrl[BIT_FAULT_CLEAR]),
    .hit(fault_clear_hit)
  );

  ddti_width_qual #(.MIN_CYC(RTZ_MIN_CYC)) u_rtz (
    .clk_sys(clk_sys),
    .srst(srst),
    .level(ctrl[BIT_RTZ]),
    .hit(rtz_hit)
  );

  always_comb begin
    logic cyl_edge;
    logic head_edge;
    logic wg;
    logic rg;
    logic mark_en;
    logic [1:0] offset_req;
    logic maint_unit;
    logic fault_cond;
    logic write_fault;
    logic unit_match;
    logic [13:0] sec_size;
    logic rd_access;
    logic wr_access;
    st_nxt = st_r;
    cyl_edge = 1'b0;
    head_edge = 1'b0;
    wg = ctrl[BIT_WRITE_GATE];
    rg = ctrl[BIT_READ_GATE];
    mark_en = ctrl[BIT_MARK_ENABLE];
    offset_req = 2'b00;
    maint_unit = 1'b0;
    fault_cond = 1'b0;
    write_fault = 1'b0;
    unit_match = 1'b0;
    sec_size = 14'h0000;
    rd_access = 1'b0;
    wr_access = 1'b0;

    // Unit compare is gated by the tag and lost with the cable; one cycle meets 200 ns
    unit_match = cable.unit_num == st_r.cfg[CFG_UNIT_LSB +: 4];
    st_nxt.stat.unit_selected = cable.unit_tag && unit_match && cable.cable_ok;
    maint_unit = st_r.cfg[CFG_UNIT_LSB +: 4] >= MAINT_UNIT_LO;

    // Strobe edges from the selected unit only
    st_nxt.cyl_tag_d = cable.cyl_tag && selected;
    st_nxt.head_tag_d = cable.head_tag && selected;
    cyl_edge = cable.cyl_tag && selected && !st_r.cyl_tag_d;
    head_edge = cable.head_tag && selected && !st_r.head_tag_d;

    // Single pulses default low
    st_nxt.cmd.seek_go = 1'b0;
    st_nxt.cmd.return_to_zero_cmd = 1'b0;
    st_nxt.cmd.separator_sync = 1'b0;

    // Both offsets together is illegal; holding neither is the safe reading
    if (ctrl[BIT_OFFSET_PLUS] != ctrl[BIT_OFFSET_MINUS]) begin
      offset_req = {ctrl[BIT_OFFSET_MINUS], ctrl[BIT_OFFSET_PLUS]};
    end
    st_nxt.cmd.offset_plus = offset_req[0];
    st_nxt.cmd.offset_minus = offset_req[1];
    st_nxt.offset_d = offset_req;
    st_nxt.cmd.strobe_early = ctrl[BIT_STROBE_EARLY] && !ctrl[BIT_STROBE_LATE];
    st_nxt.cmd.strobe_late = ctrl[BIT_STROBE_LATE] && !ctrl[BIT_STROBE_EARLY];
    st_nxt.cmd.margin_mode = ctrl[BIT_RELEASE] && maint_unit;

    // Head register; a fixed-head unit is on cylinder once a track is chosen
    if (head_edge) begin
      st_nxt.cmd.head = cable.bus[4:0];
      if (FIXED_HEAD) begin
        st_nxt.stat.on_cylinder = !st_r.stat.seek_error;
      end
    end

    if (st_r.blank != 12'h000) begin
      st_nxt.blank = st_r.blank - 12'h001;
    end

    // Positioner sequencing
    case (st_r.sk)
      DDTI_SK_IDLE: begin
        if (st_r.offset_d != offset_req) begin
          st_nxt.stat.on_cylinder = 1'b0;
          st_nxt.settle = 20'(OFFSET_SETTLE);
          st_nxt.blank = 12'(SEEK_END_BLANK_CYC);
          st_nxt.sk = DDTI_SK_SETTLE;
        end
      end
      DDTI_SK_MOVE, DDTI_SK_RTZ: begin
        if (sense.seek_late && st_r.sk == DDTI_SK_MOVE) begin
          st_nxt.stat.seek_error = 1'b1;
          st_nxt.sk = DDTI_SK_IDLE;
        end else if (sense.heads_on_track && st_r.blank == 12'h000) begin
          st_nxt.stat.on_cylinder = 1'b1;
          st_nxt.sk = DDTI_SK_IDLE;
        end
      end
      DDTI_SK_SETTLE: begin
        // Settle timer bounds the loss of on-cylinder, also covering a direction change
        if (st_r.settle != 20'h00000) begin
          st_nxt.settle = st_r.settle - 20'h00001;
        end else begin
          st_nxt.stat.on_cylinder = !st_r.stat.seek_error;
          st_nxt.sk = DDTI_SK_IDLE;
        end
        if (st_r.offset_d != offset_req) begin
          st_nxt.settle = 20'(OFFSET_SETTLE);
          st_nxt.blank = 12'(SEEK_END_BLANK_CYC);
          st_nxt.stat.on_cylinder = 1'b0;
          st_nxt.sk = DDTI_SK_SETTLE;
        end
      end
      default: begin
        st_nxt.sk = DDTI_SK_IDLE;
      end
    endcase

    // Cylinder strobe: legal address starts a seek, illegal one raises seek error
    if (cyl_edge) begin
      st_nxt.stat.on_cylinder = 1'b0;
      st_nxt.blank = 12'(SEEK_END_BLANK_CYC);
      if (cable.bus > MAX_CYLINDER) begin
        st_nxt.stat.seek_error = 1'b1;
        st_nxt.sk = DDTI_SK_IDLE;
      end else begin
        st_nxt.cmd.cylinder = cable.bus;
        st_nxt.cmd.seek_go = 1'b1;
        st_nxt.sk = DDTI_SK_MOVE;
      end
    end

    // Zero return is the only way out of seek error
    if (rtz_hit) begin
      st_nxt.stat.seek_error = 1'b0;
      st_nxt.stat.on_cylinder = 1'b0;
      st_nxt.cmd.cylinder = 10'h000;
      st_nxt.cmd.head = 5'h00;
      st_nxt.cmd.return_to_zero_cmd = 1'b1;
      st_nxt.blank = 12'(SEEK_END_BLANK_CYC);
      st_nxt.sk = DDTI_SK_RTZ;
    end
    if (st_nxt.stat.seek_error) begin
      st_nxt.stat.on_cylinder = 1'b0;
    end
    st_nxt.stat.seek_end = (st_nxt.stat.on_cylinder || st_nxt.stat.seek_error)
      && st_nxt.blank == 12'h000;

    // Fault sources; mark erase and maintenance release mask write current checks
    write_fault = (sense.write_current != wg) && !(mark_en && wg) && !st_nxt.cmd.margin_mode;
    fault_cond = sense.multi_head
      || (wg && st_r.cfg[CFG_WPROT])
      || ((2'(cable.cyl_tag) + 2'(cable.head_tag) + 2'(cable.ctrl_tag)) > 2'd1 && selected)
      || ((wg || rg) && !st_r.stat.on_cylinder)
      || (wg && rg)
      || (wg && offset_req != 2'b00)
      || write_fault
      || (st_r.cfg[CFG_PARTNER_EN]
        && st_r.cfg[CFG_PARTNER_LSB +: 4] == st_r.cfg[CFG_UNIT_LSB +: 4]);
    // A live condition wins over the clear
    if (fault_cond) begin
      st_nxt.stat.fault = 1'b1;
    end else if (fault_clear_hit) begin
      st_nxt.stat.fault = 1'b0;
    end

    st_nxt.stat.ready = sense.at_speed && sense.heads_on_track && !st_nxt.stat.fault;
    st_nxt.cmd.write_driver_en = wg && !st_r.stat.fault && st_r.stat.on_cylinder
      && !st_r.stat.seek_error && st_r.stat.ready && cable.cable_ok;
    st_nxt.cmd.read_data_en = rg;
    st_nxt.read_gate_d = rg;
    st_nxt.cmd.separator_sync = rg && !st_r.read_gate_d;
    st_nxt.cmd.mark_write_detect_enable = mark_en && wg;

    // Mark detection counts bit cells with no read signal
    if (!(mark_en && rg)) begin
      st_nxt.miss_cnt = 5'h00;
      st_nxt.mark_done = 1'b0;
    end else if (sense.bit_tick && !st_r.mark_done) begin
      if (!sense.read_signal) begin
        if (st_r.miss_cnt != 5'h1f) begin
          st_nxt.miss_cnt = st_r.miss_cnt + 5'h01;
        end
      end else begin
        // The first read signal after a long enough gap reports the mark
        if (st_r.miss_cnt > 5'(MISSING_BITS_MIN)) begin
          st_nxt.mark_done = 1'b1;
          st_nxt.mark_cnt = 10'(MARK_PULSE_CYC);
        end
        st_nxt.miss_cnt = 5'h00;
      end
    end
    if (st_r.mark_cnt != 10'h000) begin
      st_nxt.mark_cnt = st_r.mark_cnt - 10'h001;
    end
    st_nxt.stat.mark_found_pulse = st_nxt.mark_cnt != 10'h000;

    // Sector and index marks run free of selection; the last sector may run long
    sec_size = st_r.cfg[CFG_SECTOR_LSB +: 14];
    if (sec_size < SECTOR_BYTES_MIN) begin
      sec_size = SECTOR_BYTES_MIN;
    end
    if (st_r.index_cnt != 9'h000) begin
      st_nxt.index_cnt = st_r.index_cnt - 9'h001;
    end
    if (st_r.sector_cnt != 9'h000) begin
      st_nxt.sector_cnt = st_r.sector_cnt - 9'h001;
    end
    if (sense.byte_tick) begin
      if (st_r.trk_bytes == 16'(BYTES_PER_TRACK - 1)) begin
        st_nxt.trk_bytes = 16'h0000;
        st_nxt.sec_bytes = 14'h0000;
        st_nxt.index_cnt = 9'(INDEX_PULSE_CYC);
        st_nxt.sector_cnt = 9'(INDEX_PULSE_CYC);
      end else begin
        st_nxt.trk_bytes = st_r.trk_bytes + 16'h0001;
        st_nxt.sec_bytes = st_r.sec_bytes + 14'h0001;
        if (st_r.sec_bytes >= sec_size - 14'h0001
          && 17'(BYTES_PER_TRACK) - 17'(st_r.trk_bytes) > 17'(sec_size)) begin
          st_nxt.sec_bytes = 14'h0000;
          st_nxt.sector_cnt = 9'(INDEX_PULSE_CYC);
        end
      end
    end
    st_nxt.stat.index = st_nxt.index_cnt != 9'h000;
    st_nxt.stat.sector = st_nxt.sector_cnt != 9'h000;

    // APB slave: one wait state, writes land on the completing edge
    rd_access = apb_req.psel && apb_req.penable && !st_r.rsp.pready;
    wr_access = apb_req.psel && apb_req.penable && st_r.rsp.pready && apb_req.pwrite;
    st_nxt.rsp.pready = rd_access;
    if (rd_access) begin
      st_nxt.rsp.pslverr = 1'b0;
      if (apb_req.paddr == ADDR_CONFIG) begin
        st_nxt.rsp.prdata = st_r.cfg;
      end else if (apb_req.paddr == ADDR_STATUS) begin
        st_nxt.rsp.prdata = {21'h000000, st_r.sk, st_r.stat};
      end else if (apb_req.paddr == ADDR_POSITION) begin
        st_nxt.rsp.prdata = {11'h000, st_r.cmd.head, 6'h00, st_r.cmd.cylinder};
      end else begin
        st_nxt.rsp.prdata = 32'h00000000;
        st_nxt.rsp.pslverr = 1'b1;
      end
    end else if (!st_r.rsp.pready) begin
      st_nxt.rsp.prdata = 32'h00000000;
      st_nxt.rsp.pslverr = 1'b0;
    end
    if (wr_access && apb_req.paddr == ADDR_CONFIG) begin
      st_nxt.cfg = {2'h0, apb_req.pwdata[29:16], 6'h00, apb_req.pwdata[9:0]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
      st_r.cfg <= CONFIG_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apb_rsp = st_r.rsp;
  assign stat = st_r.stat;
  assign cmd = st_r.cmd;
endmodule
`default_nettype wire

// File: verilog/ddti_pkg.sv
// Package: constants, carriers and state type of the disc drive tag interface
package ddti_pkg;

  // Clock and timing figures
  localparam int CLK_PERIOD_PS = 8000;
  localparam int INDEX_PULSE_NS = 2500;
  localparam int FAULT_CLR_MIN_NS = 100;
  localparam int RTZ_MIN_NS = 250;
  localparam int MARK_PULSE_NS = 4000;
  localparam int SEEK_END_BLANK_US = 30;
  localparam int OFFSET_SETTLE_US = 3200;
  // Least times round up, longest times round down
  localparam int INDEX_PULSE_CYC = (INDEX_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FAULT_CLR_CYC = (FAULT_CLR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RTZ_MIN_CYC = (RTZ_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MARK_PULSE_CYC = (MARK_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int SEEK_END_BLANK_CYC =
    (SEEK_END_BLANK_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int OFFSET_SETTLE_CYC = (OFFSET_SETTLE_US * 1000) / (CLK_PERIOD_PS / 1000);

  // Addressing limits and bus-line positions
  localparam logic [9:0] MAX_CYLINDER = 10'h152;
  localparam logic [3:0] MAINT_UNIT_LO = 4'he;
  localparam int MISSING_BITS_MIN = 16;
  localparam int BIT_WRITE_GATE = 0;
  localparam int BIT_READ_GATE = 1;
  localparam int BIT_OFFSET_PLUS = 2;
  localparam int BIT_OFFSET_MINUS = 3;
  localparam int BIT_FAULT_CLEAR = 4;
  localparam int BIT_MARK_ENABLE = 5;
  localparam int BIT_RTZ = 6;
  localparam int BIT_STROBE_EARLY = 7;
  localparam int BIT_STROBE_LATE = 8;
  localparam int BIT_RELEASE = 9;

  // Register map
  localparam logic [11:0] ADDR_CONFIG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_POSITION = 12'h008;
  localparam int CFG_UNIT_LSB = 0;
  localparam int CFG_PARTNER_LSB = 4;
  localparam int CFG_PARTNER_EN = 8;
  localparam int CFG_WPROT = 9;
  localparam int CFG_SECTOR_LSB = 16;
  localparam int POS_HEAD_LSB = 16;
  localparam logic [13:0] SECTOR_BYTES_RST = 14'h0200;
  localparam logic [13:0] SECTOR_BYTES_MIN = 14'h0002;
  localparam logic [31:0] CONFIG_RST = {2'h0, SECTOR_BYTES_RST, 16'h0010};

  typedef enum logic [1:0] {
    DDTI_SK_IDLE = 2'b00,
    DDTI_SK_MOVE = 2'b01,
    DDTI_SK_SETTLE = 2'b11,
    DDTI_SK_RTZ = 2'b10
  } ddti_seek_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ddti_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } ddti_apb_rsp_t;

  // Controller cable inputs
  typedef struct packed {
    logic cable_ok;
    logic unit_tag;
    logic [3:0] unit_num;
    logic cyl_tag;
    logic head_tag;
    logic ctrl_tag;
    logic [9:0] bus;
  } ddti_cable_t;

  // Mechanism and read channel sense inputs
  typedef struct packed {
    logic at_speed;
    logic heads_on_track;
    logic seek_late;
    logic multi_head;
    logic write_current;
    logic read_signal;
    logic bit_tick;
    logic byte_tick;
  } ddti_sense_t;

  // Status reported to the controller
  typedef struct packed {
    logic unit_selected;
    logic ready;
    logic on_cylinder;
    logic seek_error;
    logic seek_end;
    logic fault;
    logic mark_found_pulse;
    logic index;
    logic sector;
  } ddti_stat_t;

  // Commands to the servo and data channels
  typedef struct packed {
    logic write_driver_en;
    logic read_data_en;
    logic separator_sync;
    logic mark_write_detect_enable;
    logic offset_plus;
    logic offset_minus;
    logic strobe_early;
    logic strobe_late;
    logic margin_mode;
    logic seek_go;
    logic return_to_zero_cmd;
    logic [9:0] cylinder;
    logic [4:0] head;
  } ddti_cmd_t;

endpackage

// File: verilog/ddti_width_qual.sv
// Pulse-width qualifier: one-cycle hit once a level has been held long enough
`timescale 1ns/1ps
`default_nettype none
module ddti_width_qual
  import ddti_pkg::*;
#(
  parameter int MIN_CYC = 13
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic level,
  output logic hit
);

  typedef struct packed {
    logic [15:0] cnt;
    logic hit;
  } ddti_wq_state_t;

  ddti_wq_state_t st_r;
  ddti_wq_state_t st_nxt;

  initial begin
    if (MIN_CYC < 1 || MIN_CYC > 65534) begin
      $error("ddti_width_qual: MIN_CYC out of range");
    end
  end

  // Count held cycles; the hit fires once per held level, not again until release
  always_comb begin
    st_nxt = st_r;
    st_nxt.hit = 1'b0;
    if (!level) begin
      st_nxt.cnt = 16'h0000;
    end else if (st_r.cnt != 16'hffff) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
      if (st_r.cnt == 16'(MIN_CYC - 1)) begin
        st_nxt.hit = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign hit = st_r.hit;
endmodule
`default_nettype wire

// File: verif/ddti_drive_sva.sv
// Checker: port-level properties of the drive tag interface
`timescale 1ns/1ps
`default_nettype none
module ddti_drive_sva
  import ddti_pkg::*;
#(
  parameter int OFFSET_SETTLE = 50
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire ddti_apb_req_t apb_req,
  input wire ddti_apb_rsp_t apb_rsp,
  input wire ddti_cable_t cable,
  input wire ddti_sense_t sense,
  input wire ddti_stat_t stat,
  input wire ddti_cmd_t cmd
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Unit number the bench keeps configured
  localparam logic [3:0] BENCH_UNIT = 4'h0;
  int unsigned lo_cnt;

  // Cycles spent off cylinder; a cylinder strobe restarts the count
  always_ff @(posedge clk_sys) begin
    if (srst || stat.on_cylinder || cable.cyl_tag) begin
      lo_cnt <= 0;
    end else begin
      lo_cnt <= lo_cnt + 1;
    end
  end

  // Tag edges that act only on a selected unit
  sequence s_cyl;
    $rose(cable.cyl_tag) && stat.unit_selected;
  endsequence
  sequence s_head;
    $rose(cable.head_tag) && stat.unit_selected;
  endsequence

  AST_SEL_OPEN: assert property (!cable.cable_ok |=> !stat.unit_selected)
    else $error("unit selected with cable open");
  AST_SEL_TIME: assert property (cable.unit_tag && cable.cable_ok && cable.unit_num == BENCH_UNIT
    |=> stat.unit_selected) else $error("matching unit not selected");
  AST_CYL_ILL: assert property (s_cyl ##0 (cable.bus > MAX_CYLINDER) |=> stat.seek_error)
    else $error("illegal cylinder without seek error");
  AST_CYL_LOAD: assert property (s_cyl ##0 (cable.bus <= MAX_CYLINDER)
    |=> cmd.cylinder == $past(cable.bus)) else $error("cylinder not loaded");
  AST_SEEK_CLR: assert property (s_cyl |=> !stat.on_cylinder && !stat.seek_end)
    else $error("seek left on cylinder set");
  AST_HEAD: assert property (s_head |=> cmd.head == $past(cable.bus[4:0]))
    else $error("head not loaded from low bus bits");
  AST_WR_BLOCK: assert property (cable.ctrl_tag && cable.bus[BIT_WRITE_GATE]
    && (stat.seek_error || stat.fault) |=> !cmd.write_driver_en) else $error("write not blocked");
  AST_SERR_ONCYL: assert property (stat.seek_error |-> !stat.on_cylinder)
    else $error("on cylinder during seek error");
  AST_RTZ: assert property (cmd.return_to_zero_cmd |-> ##[0:1]
    (cmd.head == 5'h00 && !stat.seek_error)) else $error("return to zero left state");
  AST_CTRL_GATE: assert property (!cable.ctrl_tag |=> !(cmd.write_driver_en ||
    cmd.read_data_en || cmd.offset_plus || cmd.offset_minus || cmd.strobe_early ||
    cmd.strobe_late)) else $error("control level without control tag");
  AST_MARK: assert property ($rose(stat.mark_found_pulse) |-> ##[1:1000]
    !stat.mark_found_pulse) else $error("mark found pulse too long");
  AST_OFFSET: assert property ((cmd.offset_plus || cmd.offset_minus)
    |-> lo_cnt <= OFFSET_SETTLE + 2) else $error("offset settle too long");
  AST_SYNC: assert property ($rose(cmd.read_data_en) |-> cmd.separator_sync)
    else $error("no separator sync on read gate");
endmodule

bind ddti_drive ddti_drive_sva #(.OFFSET_SETTLE(OFFSET_SETTLE)) u_sva (
  .clk_sys(clk_sys), .srst(srst), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .cable(cable), .sense(sense), .stat(stat), .cmd(cmd)
);
`default_nettype wire

// File: verif/ddti_ctl_model.sv
// Controller model: drives unit, tag and bus lines of the cable
`timescale 1ns/1ps
`default_nettype none
module ddti_ctl_model
  import ddti_pkg::*;
(
  input wire logic clk_sys,
  input wire ddti_stat_t stat,
  output ddti_cable_t cable
);
  // 130 cycles sits inside the legal tag length window
  localparam int TAG_CYC = 130;

  // Cable connected, nothing asserted
  initial begin
    cable = '0;
    cable.cable_ok = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic set_ok(input logic v);
    cable.cable_ok <= v;
    hold(1);
  endtask

  // Unit tag stays up afterwards so later tags act
  task automatic select(input logic [3:0] u);
    cable.unit_num <= u;
    cable.unit_tag <= 1'b1;
    hold(2);
  endtask

  // Bus flips after the tag so stale data never looks held
  task automatic strobe(input int t, input logic [9:0] v, input int n);
    cable.bus <= v;
    cable.cyl_tag <= (t == 1);
    cable.head_tag <= (t == 2);
    cable.ctrl_tag <= (t == 3);
    hold(n);
    cable.cyl_tag <= 1'b0;
    cable.head_tag <= 1'b0;
    cable.ctrl_tag <= 1'b0;
    cable.bus <= ~v;
    hold(2);
  endtask

  task automatic wait_on(output int k);
    k = 0;
    while (stat.on_cylinder !== 1'b1 && k < 8000) begin
      @(posedge clk_sys);
      k++;
    end
  endtask

  task automatic seek(input logic [9:0] c);
    int k;
    wait_on(k);
    strobe(1, c, TAG_CYC);
  endtask

  // Control levels; an all-zero value drops the tag
  task automatic ctrl(input logic [9:0] v);
    if (v[BIT_OFFSET_PLUS]) v[BIT_OFFSET_MINUS] = 1'b0;
    cable.bus <= (v == 10'h000) ? ~cable.bus : v;
    cable.ctrl_tag <= (v != 10'h000);
    hold(1);
  endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// Testbench: drive tag interface against the controller model
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import ddti_pkg::*;
();
  localparam int SETTLE = 50;
  localparam int BPT = 40;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  ddti_apb_req_t req = '0;
  ddti_apb_rsp_t rsp;
  ddti_cable_t cable;
  ddti_sense_t sense = 8'hc0; // At speed and heads on track
  ddti_stat_t stat;
  ddti_cmd_t cmd;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int n_idx = 0;
  int k;
  int i0;
  int lv[4] = '{2, 3, 7, 8};
  logic idx_d = 1'b0;
  logic [31:0] seed = 32'hab6b54bf;
  logic [31:0] q;
  logic e;
  logic [9:0] c;

  always #4 clk_sys = ~clk_sys;

  ddti_drive #(.OFFSET_SETTLE(SETTLE), .BYTES_PER_TRACK(BPT)) uut (
    .clk_sys(clk_sys), .srst(srst), .apb_req(req), .apb_rsp(rsp), .cable(cable),
    .sense(sense), .stat(stat), .cmd(cmd)
  );
  ddti_ctl_model ctl (.clk_sys(clk_sys), .stat(stat), .cable(cable));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic exp_serr(input logic [9:0] v);
    return v > MAX_CYLINDER;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Request held until pready is sampled high; read data taken there
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Bit cells every 4 cycles, bytes every 16 so a turn outlasts the index pulse
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    sense.bit_tick <= (cyc % 4 == 0);
    sense.byte_tick <= (cyc % 16 == 2);
    idx_d <= stat.index;
    if (stat.index === 1'b1 && idx_d === 1'b0) n_idx <= n_idx + 1;
    if (cyc == 40000) begin
      n_fail++;
      print_verdict();
    end
  end

  initial begin
    repeat (10) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    check("stat_rst", 32'(stat), 32'h0);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("config_rst", q, CONFIG_RST);
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped_err", 32'(e), 32'h1);
    check("unmapped_data", q, 32'h0);
    // Partner check kept off so no fault latches before selection
    seed = lfsr(seed);
    apb(1'b1, ADDR_CONFIG, seed & 32'hfffffeff);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("config_mask", q, seed & 32'h3fff02ff);
    seed = lfsr(seed);
    apb(1'b1, ADDR_CONFIG, {2'h0, 14'h0002 + 14'(seed % 8191), 16'h0010});
    apb(1'b0, ADDR_CONFIG, 32'h0);
    check("config_rw", q, {2'h0, 14'h0002 + 14'(seed % 8191), 16'h0010});
    ctl.set_ok(1'b0);
    ctl.select(4'h0);
    check("sel_open", 32'(stat.unit_selected), 32'h0);
    ctl.select(4'h5);
    ctl.set_ok(1'b1);
    ctl.hold(1);
    check("sel_other", 32'(stat.unit_selected), 32'h0);
    ctl.select(4'h0);
    check("sel_match", 32'(stat.unit_selected), 32'h1);
    for (int r = 0; r < 3; r++) begin
      ctl.strobe(3, 10'h040, 40);
      check("rtz_head", 32'(cmd.head), 32'h0);
      check("rtz_serr", 32'(stat.seek_error), 32'h0);
      ctl.wait_on(k);
      ctl.hold(2);
      check("ready", 32'(stat.ready), 32'h1);
      check("seek_end", 32'(stat.seek_end), 32'h1);
      for (int i = 0; i < 5 && r == 0; i++) begin
        seed = lfsr(seed);
        c = (i == 0) ? MAX_CYLINDER : (i == 4) ? 10'(339 + seed % 685) : 10'(seed % 339);
        ctl.seek(c);
        check("seek_err", 32'(stat.seek_error), 32'(exp_serr(c)));
        if (!exp_serr(c)) begin
          ctl.wait_on(k);
          apb(1'b0, ADDR_POSITION, 32'h0);
          check("cylinder", 32'(q[9:0]), 32'(c));
          ctl.strobe(2, seed[17:8], 130);
          check("head", 32'(cmd.head), 32'(seed[12:8]));
        end
      end
      if (r == 0) begin
        check("serr_oncyl", 32'(stat.on_cylinder), 32'h0);
        ctl.ctrl(10'h001);
        ctl.hold(4);
        check("wr_blocked", 32'(cmd.write_driver_en), 32'h0);
        check("fault_set", 32'(stat.fault), 32'h1);
        check("ready_fault", 32'(stat.ready), 32'h0);
        ctl.ctrl(10'h000);
        sense.multi_head <= 1'b1;
        ctl.strobe(3, 10'h010, 20);
        check("fault_held", 32'(stat.fault), 32'h1);
        sense.multi_head <= 1'b0;
        ctl.strobe(3, 10'h010, 20);
        check("fault_clr", 32'(stat.fault), 32'h0);
      end else if (r == 1) begin
        sense.at_speed <= 1'b0;
        ctl.hold(2);
        check("ready_speed", 32'(stat.ready), 32'h0);
        sense.at_speed <= 1'b1;
        sense.heads_on_track <= 1'b0;
        ctl.hold(2);
        check("ready_track", 32'(stat.ready), 32'h0);
        sense.heads_on_track <= 1'b1;
        sense.seek_late <= 1'b1;
        ctl.seek(10'h001);
        check("seek_late", 32'(stat.seek_error), 32'h1);
        sense.seek_late <= 1'b0;
      end else begin
        sense.write_current <= 1'b1;
        ctl.ctrl(10'h001);
        ctl.hold(2);
        check("wr_en", 32'(cmd.write_driver_en), 32'h1);
        ctl.ctrl(10'h021);
        sense.write_current <= 1'b0;
        ctl.hold(2);
        check("am_write", 32'({cmd.mark_write_detect_enable, stat.fault}), 32'h2);
        ctl.ctrl(10'h000);
      end
    end
    foreach (lv[j]) begin
      ctl.ctrl(10'(1 << lv[j]));
      ctl.hold(3);
      check("level_on", 32'({cmd.offset_plus, cmd.offset_minus, cmd.strobe_early,
        cmd.strobe_late}), 32'({lv[j] == 2, lv[j] == 3, lv[j] == 7, lv[j] == 8}));
      check("oncyl_lvl", 32'(stat.on_cylinder), 32'(lv[j] > 3));
      ctl.wait_on(k);
      check("settle", 32'(k <= SETTLE + 2), 32'h1);
      check("seek_end_off", 32'(stat.seek_end), 32'h0);
      ctl.ctrl(10'h000);
      ctl.hold(3);
      check("level_off", 32'({cmd.offset_plus, cmd.offset_minus, cmd.strobe_early,
        cmd.strobe_late}), 32'h0);
      ctl.wait_on(k);
    end
    sense.read_signal <= 1'b1;
    ctl.ctrl(10'h022);
    ctl.hold(3);
    check("read_en", 32'(cmd.read_data_en), 32'h1);
    for (int m = 16; m < 18; m++) begin
      sense.read_signal <= 1'b0;
      ctl.hold(4 * m);
      sense.read_signal <= 1'b1;
      ctl.hold(8);
      check("mark_found", 32'(stat.mark_found_pulse), 32'(m > MISSING_BITS_MIN));
    end
    ctl.ctrl(10'h002);
    ctl.ctrl(10'h000);
    i0 = n_idx;
    ctl.hold(3 * 16 * BPT);
    check("index_count", 32'(n_idx - i0), 32'h3);
    ctl.select(4'he);
    apb(1'b1, ADDR_CONFIG, 32'h0200001e);
    ctl.ctrl(10'h200);
    ctl.hold(1);
    check("margin", 32'(cmd.margin_mode), 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
